/* File: shared/wsw_pkg.sv */
// Register map, field positions, reset values and service codes of the watchdog.
// Assumes a 32-bit peripheral bus that presents byte offsets within the block.
package wsw_pkg;

    // Register offsets
    localparam logic [7:0] OFF_CTRL  = 8'h00;
    localparam logic [7:0] OFF_IFLAG = 8'h04;
    localparam logic [7:0] OFF_TO    = 8'h08;
    localparam logic [7:0] OFF_WIN   = 8'h0c;
    localparam logic [7:0] OFF_SVC   = 8'h10;
    localparam logic [7:0] OFF_COUNT = 8'h14;

    // Control and interrupt flag register fields
    localparam int CTRL_WEN        = 0;
    localparam int CTRL_DBG_FREEZE = 1;
    localparam int CTRL_STOP_HALT  = 2;
    localparam int CTRL_CLK_SEL    = 3;
    localparam int CTRL_SOFT_LOCK  = 4;
    localparam int CTRL_HARD_LOCK  = 5;
    localparam int CTRL_IRQ_FIRST  = 6;
    localparam int CTRL_WINDOW     = 7;
    localparam int CTRL_BAD_RESET  = 8;
    localparam int CTRL_KEY        = 9;
    localparam int CTRL_PERM_MSB   = 31;
    localparam int IFLAG_TIMEOUT   = 0;

    // Reset values and writable bits
    localparam logic [31:0] CTRL_RESET = 32'h4000_011b;
    localparam logic [31:0] CTRL_MASK  = 32'hff00_03ff;
    localparam logic [31:0] TO_RESET   = 32'h0000_0500;
    localparam logic [31:0] WIN_RESET  = 32'h0000_0000;
    localparam logic [31:0] TO_MIN     = 32'h0000_0100;
    localparam logic [15:0] KEY_RESET  = 16'h0000;

    // Service and unlock codes
    localparam logic [15:0] SVC_FIRST  = 16'ha602;
    localparam logic [15:0] SVC_SECOND = 16'hb480;
    localparam logic [15:0] UNL_FIRST  = 16'hc520;
    localparam logic [15:0] UNL_SECOND = 16'hd928;

    // Key update: next = key * 17 + 3
    localparam logic [15:0] KEY_MUL = 16'h0011;
    localparam logic [15:0] KEY_ADD = 16'h0003;

    // Bus access size code for a word
    localparam logic [1:0] SIZE_WORD = 2'h2;

endpackage : wsw_pkg

/* File: tb/windowed_software_watchdog_test.sv */
// Self-checking bench for the watchdog core, one task per scenario.
// Assumes the master model drives the register bus; ticks and modes come from here.
module windowed_software_watchdog_test;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [7:0]  A_CR = wsw_pkg::OFF_CTRL;
    localparam logic [7:0]  A_IR = wsw_pkg::OFF_IFLAG;
    localparam logic [7:0]  A_TO = wsw_pkg::OFF_TO;
    localparam logic [7:0]  A_WN = wsw_pkg::OFF_WIN;
    localparam logic [7:0]  A_SR = wsw_pkg::OFF_SVC;
    localparam logic [7:0]  A_CO = wsw_pkg::OFF_COUNT;
    localparam logic [31:0] C_OFF = 32'h4000_0108; // Unlocked, disabled

    logic        sys_clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic        osc_tick = 1'b0;
    logic        debug_mode = 1'b0;
    logic        stop_mode = 1'b0;
    logic        standby_mode = 1'b0;
    logic        reset_mode_exit = 1'b0;
    logic        user_opt_wen = 1'b0;
    logic        bus_req, bus_wr, bus_ack, bus_err, wdog_irq, wdog_reset_req;
    logic [7:0]  bus_addr;
    logic [1:0]  bus_size;
    logic [2:0]  bus_master;
    logic [31:0] bus_wdata, bus_rdata;
    int          num_errors = 0;
    int          num_checks = 0;
    int          rst_seen = 0;
    int          n;

    always #12.5 sys_clk = ~sys_clk;

    always @(posedge sys_clk)
        if (wdog_reset_req === 1'b1)
            rst_seen <= rst_seen + 1;

    wsw_core u_dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .osc_tick(osc_tick),
        .debug_mode(debug_mode), .stop_mode(stop_mode), .standby_mode(standby_mode),
        .reset_mode_exit(reset_mode_exit), .user_opt_wen(user_opt_wen), .bus_req(bus_req),
        .bus_wr(bus_wr), .bus_addr(bus_addr), .bus_size(bus_size), .bus_master(bus_master),
        .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .bus_ack(bus_ack), .bus_err(bus_err),
        .wdog_irq(wdog_irq), .wdog_reset_req(wdog_reset_req));

    wsw_master_model u_master (.sys_clk(sys_clk), .bus_rdata(bus_rdata), .bus_ack(bus_ack),
        .bus_err(bus_err), .bus_req(bus_req), .bus_wr(bus_wr), .bus_addr(bus_addr),
        .bus_size(bus_size), .bus_master(bus_master), .bus_wdata(bus_wdata));

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic acc(input logic w, input logic [7:0] a, input logic [1:0] sz,
                       input logic [2:0] m, input logic [31:0] d, input logic e,
                       input logic [31:0] exp);
        logic [31:0] rdata_seen;
        logic        ack, err;
        u_master.access(w, a, sz, m, d, rdata_seen, ack, err);
        check("answer", {30'h0, ack, err}, {30'h0, ~e, e});
        check("rdata", rdata_seen, exp);
    endtask : acc

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic e);
        acc(1'b1, a, wsw_pkg::SIZE_WORD, 3'h1, d, e, 32'h0);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        acc(1'b0, a, wsw_pkg::SIZE_WORD, 3'h1, 32'h0, 1'b0, exp);
    endtask : rd

    task automatic tick(input int k);
        repeat (k)
        begin
            @(posedge sys_clk);
            osc_tick <= 1'b1;
            @(posedge sys_clk);
            osc_tick <= 1'b0;
        end
    endtask : tick

    task automatic modes(input logic d, input logic s);
        @(posedge sys_clk);
        debug_mode <= d;
        stop_mode  <= s;
    endtask : modes

    task automatic resets_since(input int exp);
        repeat (3) @(posedge sys_clk);
        #1;
        check("reset requests", 32'(rst_seen - n), 32'(exp));
    endtask : resets_since

    task automatic test_reset_values;
        rd(A_CR, wsw_pkg::CTRL_RESET);
        rd(A_TO, 32'h0000_0500);
        rd(A_WN, 32'h0);
        rd(A_CO, 32'h0);
        rd(A_IR, 32'h0);
    endtask : test_reset_values

    task automatic test_bad_access;
        n = rst_seen;
        acc(1'b0, A_CR, 2'h1, 3'h1, 32'h0, 1'b1, 32'h0);
        acc(1'b0, A_CR, 2'h2, 3'h0, 32'h0, 1'b1, 32'h0);
        acc(1'b0, 8'h18, 2'h2, 3'h1, 32'h0, 1'b1, 32'h0);
        wr(A_CO, 32'h1, 1'b1);
        wr(A_TO, 32'h10, 1'b1);
        wr(A_SR, 32'h1234, 1'b1);
        resets_since(6);
    endtask : test_bad_access

    task automatic test_unlock;
        wr(A_SR, wsw_pkg::UNL_FIRST, 1'b0);
        wr(A_SR, wsw_pkg::UNL_SECOND, 1'b0);
        rd(A_CR, wsw_pkg::CTRL_RESET & ~32'h10);
    endtask : test_unlock

    task automatic test_counting;
        wr(A_CR, C_OFF, 1'b0);
        wr(A_TO, 32'h10, 1'b0);
        wr(A_CR, C_OFF | 32'h7, 1'b0);
        tick(3);
        modes(1'b1, 1'b0);
        tick(2);
        modes(1'b0, 1'b1);
        tick(2);
        modes(1'b0, 1'b0);
        rd(A_CO, 32'h0);
        wr(A_CR, C_OFF, 1'b0);
        rd(A_CO, 32'h100 - 32'h3);
        wr(A_CR, 32'h4000_0101, 1'b0);
        modes(1'b1, 1'b0);
        tick(2);
        modes(1'b0, 1'b1);
        tick(2);
        modes(1'b0, 1'b0);
        wr(A_CR, 32'h4000_0100, 1'b0);
        rd(A_CO, 32'h100 - 32'h4);
    endtask : test_counting

    task automatic test_service;
        wr(A_TO, 32'h200, 1'b0);
        wr(A_CR, C_OFF | 32'h1, 1'b0);
        tick(5);
        wr(A_SR, wsw_pkg::SVC_FIRST, 1'b0);
        wr(A_SR, wsw_pkg::UNL_FIRST, 1'b0);
        wr(A_SR, wsw_pkg::SVC_SECOND, 1'b0);
        wr(A_CR, C_OFF, 1'b0);
        rd(A_CO, 32'h200);
    endtask : test_service

    task automatic test_window;
        wr(A_TO, 32'h100, 1'b0);
        wr(A_WN, 32'h80, 1'b0);
        wr(A_CR, C_OFF | 32'h81, 1'b0);
        wr(A_SR, wsw_pkg::SVC_FIRST, 1'b1);
        tick(32'h81);
        wr(A_SR, wsw_pkg::SVC_FIRST, 1'b0);
        wr(A_SR, wsw_pkg::SVC_SECOND, 1'b0);
        wr(A_CR, C_OFF, 1'b0);
        rd(A_CO, 32'h100);
    endtask : test_window

    task automatic test_timeout;
        n = rst_seen;
        wr(A_CR, C_OFF | 32'h1, 1'b0);
        tick(32'h100);
        resets_since(0);
        tick(1);
        resets_since(1);
        wr(A_CR, C_OFF, 1'b0);
        n = rst_seen;
        wr(A_CR, C_OFF | 32'h41, 1'b0);
        tick(32'h101);
        resets_since(0);
        check("irq", {31'h0, wdog_irq}, 32'h1);
        wr(A_IR, 32'h0, 1'b0);
        rd(A_IR, 32'h1);
        tick(32'h100);
        resets_since(0);
        tick(1);
        resets_since(1);
        wr(A_IR, 32'h1, 1'b0);
        rd(A_IR, 32'h0);
        check("irq", {31'h0, wdog_irq}, 32'h0);
    endtask : test_timeout

    task automatic test_lock_standby;
        wr(A_CR, C_OFF | 32'h20, 1'b0);
        n = rst_seen;
        wr(A_SR, wsw_pkg::UNL_FIRST, 1'b0);
        wr(A_SR, wsw_pkg::UNL_SECOND, 1'b0);
        wr(A_CR, C_OFF, 1'b1);
        resets_since(0);
        rd(A_CR, C_OFF | 32'h20);
        @(posedge sys_clk);
        standby_mode <= 1'b1;
        @(posedge sys_clk);
        standby_mode <= 1'b0;
        rd(A_CR, wsw_pkg::CTRL_RESET);
        leave_reset_mode(1'b1);
        rd(A_CR, wsw_pkg::CTRL_RESET);
        leave_reset_mode(1'b0);
        rd(A_CR, wsw_pkg::CTRL_RESET & ~32'h1);
        rd(A_CO, 32'h500);
    endtask : test_lock_standby

    task automatic leave_reset_mode(input logic opt);
        @(posedge sys_clk);
        user_opt_wen    <= opt;
        reset_mode_exit <= 1'b1;
        @(posedge sys_clk);
        reset_mode_exit <= 1'b0;
    endtask : leave_reset_mode

    task automatic test_keyed;
        wr(A_SR, wsw_pkg::UNL_FIRST, 1'b0);
        wr(A_SR, wsw_pkg::UNL_SECOND, 1'b0);
        wr(A_TO, 32'h180, 1'b0);
        wr(A_CR, 32'h4000_0309, 1'b0);
        tick(4);
        wr(A_SR, wsw_pkg::SVC_FIRST, 1'b1);
        wr(A_SR, 32'h0000_0003, 1'b0);
        wr(A_SR, 32'h0000_0036, 1'b0);
        wr(A_CR, 32'h4000_0308, 1'b0);
        rd(A_CO, 32'h180);
    endtask : test_keyed

    task automatic report_and_stop;
        $display("Checks %0d, mismatches %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : report_and_stop

    initial
    begin
        repeat (20000) @(posedge sys_clk);
        num_errors++;
        report_and_stop();
    end

    initial
    begin
        repeat (6) @(posedge sys_clk);
        sys_rst <= 1'b0;
        test_reset_values();
        test_bad_access();
        test_unlock();
        test_counting();
        test_service();
        test_window();
        test_timeout();
        test_lock_standby();
        test_keyed();
        report_and_stop();
    end

endmodule : windowed_software_watchdog_test

/* File: tb/wsw_master_model.sv */
// Bus master model: issues one-cycle register requests and collects the answer.
// Assumes the watchdog answers exactly one cycle after it takes a request.
module wsw_master_model
(
    input  wire logic        sys_clk,    // System clock
    input  wire logic [31:0] bus_rdata,  // Read data
    input  wire logic        bus_ack,    // Access done
    input  wire logic        bus_err,    // Access refused
    output logic             bus_req,    // Request pulse
    output logic             bus_wr,     // Write when high
    output logic      [7:0]  bus_addr,   // Byte offset
    output logic      [1:0]  bus_size,   // Access size
    output logic      [2:0]  bus_master, // Master number
    output logic      [31:0] bus_wdata   // Write data
);
    timeunit 1ns;
    timeprecision 1ps;

    initial
    begin
        bus_req    = 1'b0;
        bus_wr     = 1'b0;
        bus_addr   = 8'hff;
        bus_size   = 2'h0;
        bus_master = 3'h7;
        bus_wdata  = 32'h0;
    end

    task automatic access(input logic wr, input logic [7:0] addr, input logic [1:0] size,
                          input logic [2:0] mst, input logic [31:0] data,
                          output logic [31:0] rdata, output logic ack, output logic err);
        @(posedge sys_clk);
        bus_req    <= 1'b1;
        bus_wr     <= wr;
        bus_addr   <= addr;
        bus_size   <= size;
        bus_master <= mst;
        bus_wdata  <= data;
        @(posedge sys_clk);
        bus_req    <= 1'b0;
        bus_addr   <= ~addr; // Released lines show no stale value
        bus_wdata  <= ~data;
        #1;
        rdata = bus_rdata;
        ack   = bus_ack;
        err   = bus_err;
    endtask : access

endmodule : wsw_master_model

/* File: verilog/wsw_core.sv */
// Windowed software watchdog: register file, service logic and down counter.
// Assumes counter ticks arrive as one-cycle pulses synchronous to sys_clk,
// and mode inputs are synchronous levels from the mode controller.

module wsw_core
(
    input  wire logic        sys_clk,        // System clock, 40 MHz
    input  wire logic        sys_rst,        // Synchronous reset, active high
    input  wire logic        osc_tick,       // One pulse per slow RC clock period
    input  wire logic        debug_mode,     // Device in debug mode
    input  wire logic        stop_mode,      // Device in stop mode
    input  wire logic        standby_mode,   // Device in standby
    input  wire logic        reset_mode_exit,// Pulse on leaving reset mode
    input  wire logic        user_opt_wen,   // User option bit 31
    input  wire logic        bus_req,        // Access request, one cycle
    input  wire logic        bus_wr,         // Write when high
    input  wire logic [7:0]  bus_addr,       // Byte offset
    input  wire logic [1:0]  bus_size,       // 0 byte, 1 half, 2 word
    input  wire logic [2:0]  bus_master,     // Requesting master number
    input  wire logic [31:0] bus_wdata,      // Write data
    output logic      [31:0] bus_rdata,      // Read data
    output logic             bus_ack,        // Access done
    output logic             bus_err,        // Access refused
    output logic             wdog_irq,       // Time-out interrupt request
    output logic             wdog_reset_req  // System reset request pulse
);

    logic [31:0] ctrl;
    logic [31:0] timeout_period;
    logic [31:0] window_start;
    logic [31:0] count;
    logic [31:0] readback;
    logic [15:0] svc_key;
    logic        timeout_flag;
    logic        second_armed;
    logic        svc_half;
    logic        unl_half;

    logic        rst_all;
    logic        wen;
    logic        locked;
    logic        run;
    logic        win_open;
    logic        addr_ok;
    logic        perm;
    logic        sel_ctrl;
    logic        sel_iflag;
    logic        sel_to;
    logic        sel_win;
    logic        sel_svc;
    logic        sel_cnt;
    logic [15:0] svc_code;
    logic [15:0] key_expect;
    logic        is_fix_a;
    logic        is_fix_b;
    logic        is_key;
    logic        is_svc_code;
    logic        is_unl;
    logic        svc_bad;
    logic        invalid;
    logic        good_wr;
    logic        svc_wr;
    logic        service_evt;
    logic        enable_evt;
    logic        timeout_evt;
    logic        load_evt;

    function automatic logic [31:0] load_value(input logic [31:0] period);
        load_value = (period < wsw_pkg::TO_MIN) ? wsw_pkg::TO_MIN : period;
    endfunction : load_value

    function automatic logic [15:0] key_next(input logic [15:0] k);
        logic [31:0] prod;
        prod     = k * wsw_pkg::KEY_MUL;
        key_next = prod[15:0] + wsw_pkg::KEY_ADD;
    endfunction : key_next

    function automatic logic perm_bit(input logic [31:0] c, input logic [2:0] m);
        perm_bit = c[wsw_pkg::CTRL_PERM_MSB - int'(m)];
    endfunction : perm_bit

    // Standby restarts the block like a fresh reset
    assign rst_all = sys_rst | standby_mode;

    assign wen    = ctrl[wsw_pkg::CTRL_WEN];
    assign locked = ctrl[wsw_pkg::CTRL_HARD_LOCK] | ctrl[wsw_pkg::CTRL_SOFT_LOCK];

    // Counter clock is the oscillator tick only; select bit has no effect
    assign run = wen
                 & ~(debug_mode & ctrl[wsw_pkg::CTRL_DBG_FREEZE])
                 & ~(stop_mode & ctrl[wsw_pkg::CTRL_STOP_HALT]);

    assign win_open = ~ctrl[wsw_pkg::CTRL_WINDOW] | (count < window_start);

    // Address and access checks
    assign addr_ok   = (bus_addr[1:0] == 2'h0) && (bus_addr <= wsw_pkg::OFF_COUNT);
    assign perm      = perm_bit(ctrl, bus_master);
    assign sel_ctrl  = bus_addr == wsw_pkg::OFF_CTRL;
    assign sel_iflag = bus_addr == wsw_pkg::OFF_IFLAG;
    assign sel_to    = bus_addr == wsw_pkg::OFF_TO;
    assign sel_win   = bus_addr == wsw_pkg::OFF_WIN;
    assign sel_svc   = bus_addr == wsw_pkg::OFF_SVC;
    assign sel_cnt   = bus_addr == wsw_pkg::OFF_COUNT;

    // Service code classification
    assign svc_code    = bus_wdata[15:0];
    assign key_expect  = key_next(svc_key);
    assign is_fix_a    = ~ctrl[wsw_pkg::CTRL_KEY] && (svc_code == wsw_pkg::SVC_FIRST);
    assign is_fix_b    = ~ctrl[wsw_pkg::CTRL_KEY] && (svc_code == wsw_pkg::SVC_SECOND);
    assign is_key      = ctrl[wsw_pkg::CTRL_KEY] && (svc_code == key_expect);
    assign is_svc_code = is_fix_a | is_fix_b | is_key;
    assign is_unl      = (svc_code == wsw_pkg::UNL_FIRST) || (svc_code == wsw_pkg::UNL_SECOND);

    // Wrong codes, or service outside the window, both only while enabled
    assign svc_bad = wen && ((~is_svc_code && ~is_unl) || (is_svc_code && ~win_open));

    always_comb
    begin
        invalid = 1'b0;
        if (bus_req)
        begin
            if (bus_size != wsw_pkg::SIZE_WORD)
                invalid = 1'b1;
            else if (!addr_ok || !perm)
                invalid = 1'b1;
            else if (bus_wr && (sel_ctrl || sel_to || sel_win) && locked)
                invalid = 1'b1;
            else if (bus_wr && sel_cnt)
                invalid = 1'b1;
            else if (bus_wr && sel_svc && svc_bad)
                invalid = 1'b1;
        end
    end

    assign good_wr     = bus_req & bus_wr & ~invalid;
    assign svc_wr      = good_wr & sel_svc;
    assign enable_evt  = good_wr & sel_ctrl & bus_wdata[wsw_pkg::CTRL_WEN] & ~wen;
    assign service_evt = svc_wr & wen & svc_half & (is_fix_b | is_key);
    assign timeout_evt = osc_tick & run & (count == 32'h0000_0000);
    assign load_evt    = enable_evt | service_evt | timeout_evt;

    // Control register
    always_ff @(posedge sys_clk)
    begin
        if (rst_all)
            ctrl <= wsw_pkg::CTRL_RESET;
        else
        begin
            if (good_wr && sel_ctrl)
            begin
                ctrl <= bus_wdata & wsw_pkg::CTRL_MASK;
                ctrl[wsw_pkg::CTRL_HARD_LOCK] <= ctrl[wsw_pkg::CTRL_HARD_LOCK]
                                                 | bus_wdata[wsw_pkg::CTRL_HARD_LOCK];
            end
            if (svc_wr && unl_half && (svc_code == wsw_pkg::UNL_SECOND))
                ctrl[wsw_pkg::CTRL_SOFT_LOCK] <= 1'b0;
            if (reset_mode_exit && !user_opt_wen)
                ctrl[wsw_pkg::CTRL_WEN] <= 1'b0;
        end
    end

    // Time-out and window registers
    always_ff @(posedge sys_clk)
    begin
        if (rst_all)
        begin
            timeout_period <= wsw_pkg::TO_RESET;
            window_start   <= wsw_pkg::WIN_RESET;
        end
        else
        begin
            if (good_wr && sel_to)
                timeout_period <= bus_wdata;
            if (good_wr && sel_win)
                window_start <= bus_wdata;
        end
    end

    // Service pair tracker; unlock codes leave it untouched, no timing limit
    always_ff @(posedge sys_clk)
    begin
        if (rst_all)
        begin
            svc_half <= 1'b0;
            svc_key  <= wsw_pkg::KEY_RESET;
        end
        else if (svc_wr && !is_unl)
        begin
            if (is_key)
            begin
                svc_key  <= key_expect;
                svc_half <= ~svc_half;
            end
            else
                svc_half <= is_fix_a;
        end
    end

    // Unlock pair tracker; service codes leave it untouched
    always_ff @(posedge sys_clk)
    begin
        if (rst_all)
            unl_half <= 1'b0;
        else if (good_wr && sel_svc && !is_svc_code)
            unl_half <= (svc_code == wsw_pkg::UNL_FIRST);
    end

    // Down counter
    always_ff @(posedge sys_clk)
    begin
        if (rst_all)
            count <= wsw_pkg::TO_RESET;
        else if (load_evt)
            count <= load_value(timeout_period);
        else if (osc_tick && run)
            count <= count - 32'h0000_0001;
    end

    // Interrupt flag and second time-out arming; the set beats the clear
    always_ff @(posedge sys_clk)
    begin
        if (rst_all)
        begin
            timeout_flag <= 1'b0;
            second_armed <= 1'b0;
        end
        else
        begin
            if (timeout_evt && ctrl[wsw_pkg::CTRL_IRQ_FIRST] && !second_armed)
            begin
                timeout_flag <= 1'b1;
                second_armed <= 1'b1;
            end
            else
            begin
                if (good_wr && sel_iflag && bus_wdata[wsw_pkg::IFLAG_TIMEOUT])
                    timeout_flag <= 1'b0;
                if (service_evt || !wen)
                    second_armed <= 1'b0;
            end
        end
    end

    assign wdog_irq = timeout_flag;

    // System reset request
    always_ff @(posedge sys_clk)
    begin
        if (rst_all)
            wdog_reset_req <= 1'b0;
        else
            wdog_reset_req <= (timeout_evt
                               && (!ctrl[wsw_pkg::CTRL_IRQ_FIRST] || second_armed))
                              || (invalid && ctrl[wsw_pkg::CTRL_BAD_RESET] && wen);
    end

    // Readback: counter value one system cycle late while disabled, zero while enabled
    always_ff @(posedge sys_clk)
    begin
        if (rst_all)
            readback <= 32'h0000_0000;
        else
            readback <= wen ? 32'h0000_0000 : count;
    end

    // Bus answer, one cycle after the request
    always_ff @(posedge sys_clk)
    begin
        if (rst_all)
        begin
            bus_ack   <= 1'b0;
            bus_err   <= 1'b0;
            bus_rdata <= 32'h0000_0000;
        end
        else
        begin
            bus_ack   <= bus_req & ~invalid;
            bus_err   <= invalid;
            bus_rdata <= 32'h0000_0000;
            if (bus_req && !bus_wr && !invalid)
            begin
                case (bus_addr)
                    wsw_pkg::OFF_CTRL:  bus_rdata <= ctrl;
                    wsw_pkg::OFF_IFLAG: bus_rdata <= {31'h0000_0000, timeout_flag};
                    wsw_pkg::OFF_TO:    bus_rdata <= timeout_period;
                    wsw_pkg::OFF_WIN:   bus_rdata <= window_start;
                    wsw_pkg::OFF_COUNT: bus_rdata <= readback;
                    default:            bus_rdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    default clocking chk_clk @(posedge sys_clk);
    endclocking

    default disable iff (rst_all);

    chk_size_error: assert property (
        bus_req && bus_size != wsw_pkg::SIZE_WORD |=> bus_err && !bus_ack)
        else $error("non-word access not refused");

    chk_master_denied: assert property (
        bus_req && !perm_bit(ctrl, bus_master) |=> bus_err)
        else $error("access by denied master not refused");

    chk_bad_access_reset: assert property (
        invalid && ctrl[wsw_pkg::CTRL_BAD_RESET] && wen |=> bus_err && wdog_reset_req)
        else $error("invalid access missed reset request");

    chk_hard_lock_sticky: assert property (
        ctrl[wsw_pkg::CTRL_HARD_LOCK] |=> ctrl[wsw_pkg::CTRL_HARD_LOCK])
        else $error("hard lock cleared");

    chk_lock_readonly: assert property (
        bus_req && bus_wr && sel_to && locked |=> $stable(timeout_period) ##0 bus_err)
        else $error("locked time-out register changed");

    chk_reload_value: assert property (
        service_evt |=> count == load_value($past(timeout_period)))
        else $error("reload value wrong");

    chk_debug_freeze: assert property (
        debug_mode && ctrl[wsw_pkg::CTRL_DBG_FREEZE] && !load_evt |=> $stable(count))
        else $error("counter moved while frozen");

    chk_readback_zero: assert property (
        wen |=> readback == 32'h0000_0000)
        else $error("readback not zero while enabled");

    chk_direct_reset: assert property (
        timeout_evt && !ctrl[wsw_pkg::CTRL_IRQ_FIRST]
        |=> wdog_reset_req ##1 (!wdog_reset_req || $past(invalid)))
        else $error("time-out without reset");

    chk_first_timeout: assert property (
        timeout_evt && ctrl[wsw_pkg::CTRL_IRQ_FIRST] && !second_armed
        |=> timeout_flag && (!wdog_reset_req || $past(invalid)))
        else $error("first time-out did not raise flag only");

    chk_window_refusal: assert property (
        bus_req && bus_wr && sel_svc && is_svc_code && !win_open && wen |=> bus_err && !bus_ack)
        else $error("service outside window not refused");

    cov_service: cover property (service_evt);
    cov_keyed_service: cover property (service_evt && ctrl[wsw_pkg::CTRL_KEY]);
    cov_second_timeout: cover property (timeout_evt && second_armed);
    cov_unlock: cover property (ctrl[wsw_pkg::CTRL_SOFT_LOCK] ##1 !ctrl[wsw_pkg::CTRL_SOFT_LOCK]);
    cov_window_refusal: cover property (bus_req && bus_wr && sel_svc && !win_open && wen);

endmodule : wsw_core
